// ---- dv/fast_read_chk.sv ----
// Purpose: port checks of the fast read engine
// Assumes: cs_n spans a ref_clk edge between frames
// Notes: lane pairing checked on spi_clk, other enable checks and flags on ref_clk
`timescale 1ns/100ps
module fast_read_chk (
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset
  input wire logic spi_clk, // link clock
  input wire logic cs_n, // select
  input wire logic quad_lane_enable_bit, // quad on
  input wire logic cont_read_active, // armed
  input wire logic data_phase_active, // data flag
  input wire logic serial_lane_zero_oe_n, // enable
  input wire logic serial_lane_one_oe_n, // enable
  input wire logic serial_lane_two_oe_n, // enable
  input wire logic serial_lane_three_oe_n, // enable
  input wire logic [23:0] mem_addr // address
);
  // enables gathered, lane three on top
  wire [3:0] oe = {serial_lane_three_oe_n, serial_lane_two_oe_n, serial_lane_one_oe_n,
    serial_lane_zero_oe_n};
  property p_idle;
    @(posedge ref_clk) disable iff (!nrst) cs_n && $past(cs_n) |-> oe == 4'hF;
  endproperty
  a_idle: assert property (p_idle)
    else $error("lane driven while deselected");
  property p_addr;
    @(posedge ref_clk) disable iff (!nrst) cs_n && $past(cs_n) |-> mem_addr == 24'h0;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address kept after deselect");
  property p_dual; @(posedge spi_clk) disable iff (!nrst) !oe[1] |-> !oe[0]; endproperty
  a_dual: assert property (p_dual)
    else $error("lane one driven alone");
  property p_quad; @(posedge spi_clk) disable iff (!nrst) !oe[2] |-> oe == 4'h0; endproperty
  a_quad: assert property (p_quad)
    else $error("quad data not on four lanes");
  // quad enable is checked at the opcode, so a long low spell forbids quad data
  property p_gate;
    @(posedge ref_clk) disable iff (!nrst) !quad_lane_enable_bit [*8] |-> oe[2];
  endproperty
  a_gate: assert property (p_gate)
    else $error("quad data while quad disabled");
  property p_on;
    @(posedge ref_clk) disable iff (!nrst) !oe[0] |-> ##[0:4] data_phase_active;
  endproperty
  a_on: assert property (p_on)
    else $error("lane driven outside data phase");
  property p_off;
    @(posedge ref_clk) disable iff (!nrst) cs_n [*6] |-> !data_phase_active;
  endproperty
  a_off: assert property (p_off)
    else $error("data flag stuck after deselect");
  property p_keep;
    @(posedge ref_clk) disable iff (!nrst) !oe[0] && !cs_n ##1 !cs_n |-> !oe[0];
  endproperty
  a_keep: assert property (p_keep)
    else $error("data stopped while selected");
  c_cont: cover property (@(posedge ref_clk) $rose(cont_read_active));
  c_quad: cover property (@(posedge spi_clk) oe == 4'h0);
  c_dual: cover property (@(posedge spi_clk) oe == 4'hC);
endmodule

// ---- dv/multi_io_fast_read_engine_test.sv ----
// Purpose: self-checking bench of the multi-lane fast read engine
// Assumes: array byte is a fixed function of its address
// Notes: each byte of an accepted read is checked against an address model; refused quad reads check released lanes
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h want %h", $time, g, e); end end
module multi_io_fast_read_engine_test
  import fast_read_pkg::*;
;
  logic ref_clk, nrst = 1'b0, quad_lane_enable_bit = 1'b0, wrap_enable = 1'b0;
  logic [1:0] wrap_len = 2'h0;
  logic cont_read_active, data_phase_active, spi_clk, cs_n;
  wire [3:0] ln, lo, oe;
  logic [23:0] mem_addr;
  logic [7:0] mem_rdata;
  int err_count = 0, checks_done = 0, cont_k = -1;
  // bytes mix the two low address bytes so a wrong step shows at once
  function automatic logic [7:0] mem_val(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  assign mem_rdata = mem_val(mem_addr);
  multi_io_fast_read_engine multi_io_fast_read_engine_i (.ref_clk, .nrst, .quad_lane_enable_bit,
    .wrap_enable, .wrap_len, .cont_read_active, .data_phase_active, .spi_clk, .cs_n,
    .serial_lane_zero_i(ln[0]), .serial_lane_one_i(ln[1]), .serial_lane_two_i(ln[2]),
    .serial_lane_three_i(ln[3]), .serial_lane_zero_o(lo[0]), .serial_lane_one_o(lo[1]),
    .serial_lane_two_o(lo[2]), .serial_lane_three_o(lo[3]), .serial_lane_zero_oe_n(oe[0]),
    .serial_lane_one_oe_n(oe[1]), .serial_lane_two_oe_n(oe[2]), .serial_lane_three_oe_n(oe[3]),
    .mem_addr, .mem_rdata);
  spi_host spi_host_i (.spi_clk, .cs_n, .ln, .dev_o(lo), .dev_oe_n(oe));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // all frames finish far inside this span
  initial begin
    #300000;
    err_count++;
    finish_test();
  end
  // one read frame; kind 1 and 3 are quad, continuous mode skips the opcode
  task automatic frame(input int k, input logic [23:0] a, input logic [7:0] m, input int n);
    int aw [4] = '{1, 1, 2, 4};
    logic [7:0] opc [4] = '{OPC_DUAL_OUT, OPC_QUAD_OUT, OPC_DUAL_IO, OPC_QUAD_IO};
    logic [23:0] msk, ea;
    logic [7:0] b;
    logic ok;
    ok = quad_lane_enable_bit || !k[0];
    msk = (24'h8 << wrap_len) - 24'h1;
    spi_host_i.frame_on();
    if (cont_k != k) spi_host_i.send(32'(opc[k]), 8, 1);
    spi_host_i.send(32'(a), 24, aw[k]);
    if (k > 1) spi_host_i.send(32'(m), 8, aw[k]);
    spi_host_i.dummy(k < 2 ? int'(DUMMY_OUT_CLKS) : k == 3 ? int'(DUMMY_QIO_CLKS) : 0);
    for (int i = 0; i < n; i++) begin
      spi_host_i.rd(k[0] ? 4 : 2, b);
      ea = (wrap_enable && k == 3) ? (a & ~msk) | (24'(a + i) & msk) : 24'(a + i);
      if (!ok) `CHK(oe, 4'hF)
      else `CHK(b, mem_val(ea))
    end
    spi_host_i.frame_off();
    if (k > 1 && ok) cont_k = m[7:4] == MODE_KEEP_NIBBLE ? k : -1;
    repeat (4) @(posedge ref_clk);
    `CHK(cont_read_active, cont_k >= 0)
  endtask
  initial begin
    void'($urandom(93));
    // the link sees reset only through its own clock, so clock it during the two cycles
    fork
      repeat (2) @(posedge ref_clk);
      begin
        spi_host_i.frame_on();
        spi_host_i.dummy(4);
      end
    join
    nrst <= 1'b1;
    spi_host_i.frame_off();
    spi_host_i.frame_on();
    spi_host_i.dummy(4);
    spi_host_i.frame_off();
    frame(1, 24'($urandom), 8'h00, 4);
    frame(3, 24'($urandom), 8'hA0, 4);
    frame(0, 24'($urandom), 8'h00, 5);
    @(posedge ref_clk) quad_lane_enable_bit <= 1'b1;
    repeat (3) @(posedge ref_clk);
    frame(1, 24'h0000FE, 8'h00, 4);
    // arm, reuse, leave, arm again, then clear with the mode reset
    for (int k = 2; k < 4; k++) begin
      frame(k, 24'($urandom), {4'hA, 4'($urandom)}, 4);
      frame(k, 24'($urandom), {4'hA, 4'($urandom)}, 4);
      frame(k, 24'($urandom), {4'h5, 4'($urandom)}, 4);
      frame(k, 24'($urandom), 8'hA3, 4);
      spi_host_i.frame_on();
      repeat (4 - k) spi_host_i.send(32'hFFFFFFFF, 32, 4);
      spi_host_i.frame_off();
      cont_k = -1;
      repeat (4) @(posedge ref_clk);
      `CHK(cont_read_active, 1'b0)
    end
    // mode reset opcode while not armed: decoded, no data returned
    spi_host_i.frame_on();
    spi_host_i.send(32'(OPC_MODE_RESET), 8, 1);
    spi_host_i.dummy(4);
    `CHK(oe, 4'hF)
    spi_host_i.frame_off();
    repeat (4) @(posedge ref_clk);
    `CHK(cont_read_active, 1'b0)
    @(posedge ref_clk) wrap_enable <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      @(posedge ref_clk) wrap_len <= 2'(j);
      repeat (3) @(posedge ref_clk);
      frame(3, 24'($urandom), 8'h00, (8 << j) + 3);
    end
    @(posedge ref_clk) wrap_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    frame(3, 24'h0001FC, 8'h00, 6);
    frame(2, 24'h0002FE, 8'h00, 4);
    finish_test();
  end
endmodule
bind multi_io_fast_read_engine fast_read_chk fast_read_chk_i (.ref_clk, .nrst, .spi_clk, .cs_n,
  .quad_lane_enable_bit, .cont_read_active, .data_phase_active, .serial_lane_zero_oe_n,
  .serial_lane_one_oe_n, .serial_lane_two_oe_n, .serial_lane_three_oe_n, .mem_addr);

// ---- dv/spi_host.sv ----
// Purpose: host controller model driving the serial link
// Assumes: 15 ns serial clock, running only inside frames
// Notes: a released lane reads as the inverse of its last value
`timescale 1ns/100ps
module spi_host (
  output logic spi_clk, // link clock
  output logic cs_n, // select
  output wire logic [3:0] ln, // lane levels
  input wire logic [3:0] dev_o, // device values
  input wire logic [3:0] dev_oe_n // device enables
);
  logic [3:0] hv = 4'h0;
  logic [3:0] he = 4'h0;
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
  end
  // device wins where it drives; stale data can never pass for a match
  assign ln = (~dev_oe_n & dev_o) | (dev_oe_n & ~(he ^ hv));
  // lanes move after the fall so the device samples them on the rise
  task automatic beat(input logic [3:0] v, input logic [3:0] e);
    hv = v;
    he = e;
    #7.5 spi_clk = 1'b1;
    #7.5 spi_clk = 1'b0;
  endtask
  // high bits first, top lane carries the top bit
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int i = n - w; i >= 0; i -= w) begin
      beat(4'(v >> i) & 4'((1 << w) - 1), 4'((1 << w) - 1));
    end
  endtask
  // dummies with every lane let go
  task automatic dummy(input int n);
    repeat (n) beat(4'h0, 4'h0);
  endtask
  task automatic rd(input int w, output logic [7:0] b);
    b = 8'h0;
    he = 4'h0;
    for (int i = 0; i < 8 / w; i++) begin
      #7.5 b = (b << w) | 8'(ln & 4'((1 << w) - 1));
      spi_clk = 1'b1;
      #7.5 spi_clk = 1'b0;
    end
  endtask
  task automatic frame_on();
    cs_n = 1'b0;
    #10;
  endtask
  task automatic frame_off();
    #10 cs_n = 1'b1;
    #60;
  endtask
endmodule

// ---- logic/multi_io_fast_read_engine.sv ----
// Purpose: serial flash command logic for dual and quad fast reads
// Assumes: host drives spi_clk and cs_n; array read is combinational
// Notes: lane pins are split into input, output and active-low enable
// Function
// - dual output read, 8 dummies then two lanes
// - no lane driven during dummy clocks
// - quad output read needs quad enable
// - quad output read, 8 dummies, four lanes
// - dual I/O: address, mode byte, data on two lanes
// - only mode upper nibble matters
// - mode Ax: next frame starts with address
// - continuous mode drops the eight opcode clocks
// - other mode value: next frame needs opcode
// - mode reset command clears continuous mode
// - quad I/O read needs quad enable
// - quad I/O address and mode on four lanes
// - held wrap setting governs quad I/O reads
// - wrap limits output to aligned section
// - wrap returns to section start until deselect
// - unwrapped reads step to next byte
// - sample on rising edge, shift on falling
`timescale 1ns/100ps
module multi_io_fast_read_engine
  import fast_read_pkg::*;
(
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic quad_lane_enable_bit, // quad reads accepted when high
  input wire logic wrap_enable, // held wrap setting for quad I/O reads
  input wire logic [1:0] wrap_len, // section: 0=8,1=16,2=32,3=64 bytes
  output logic cont_read_active, // continuous read mode armed
  output logic data_phase_active, // device is returning data
  input wire logic spi_clk, // serial clock from the host
  input wire logic cs_n, // chip select, active low
  input wire logic serial_lane_zero_i, // lane 0 pin level
  input wire logic serial_lane_one_i, // lane 1 pin level
  input wire logic serial_lane_two_i, // lane 2 pin level
  input wire logic serial_lane_three_i, // lane 3 pin level
  output logic serial_lane_zero_o, // lane 0 drive value
  output logic serial_lane_one_o, // lane 1 drive value
  output logic serial_lane_two_o, // lane 2 drive value
  output logic serial_lane_three_o, // lane 3 drive value
  output logic serial_lane_zero_oe_n, // lane 0 enable, low drives
  output logic serial_lane_one_oe_n, // lane 1 enable, low drives
  output logic serial_lane_two_oe_n, // lane 2 enable, low drives
  output logic serial_lane_three_oe_n, // lane 3 enable, low drives
  output logic [23:0] mem_addr, // array byte address
  input wire logic [7:0] mem_rdata // array byte at mem_addr
);
  // system domain: configuration registers and status synchronisers
  typedef struct packed {
    logic qe;
    logic wrap_en;
    logic [1:0] wrap_len;
    logic [1:0] cont_sync;
    logic [1:0] data_sync;
  } sys_s;

  // link domain, survives chip select: mode flag and synchronisers
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [3:0] cfg_meta;
    logic [3:0] cfg_sync;
    logic cont;
    kind_e cont_kind;
  } keep_s;

  // link domain, cleared by every deselect
  typedef struct packed {
    phase_e ph;
    kind_e kind;
    logic [4:0] cnt;
    logic [7:0] opc;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [2:0] bp;
  } frame_s;

  // falling-edge output stage
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe_n;
  } out_s;

  localparam frame_s FRAME_RST = '{ph: PH_START, kind: K_DUAL_OUT, cnt: 5'h00,
    opc: 8'h00, addr: 24'h000000, mode: 8'h00, bp: 3'h0};
  localparam out_s OUT_RST = '{dout: 4'h0, oe_n: OE_N_IDLE};

  sys_s sys_q, sys_d;
  keep_s keep_q, keep_d;
  frame_s fr_q, fr_d;
  out_s out_q, out_d;
  logic [3:0] lanes;
  logic mode_done;
  logic mode_hit;
  logic mode_clear;

  assign lanes = {serial_lane_three_i, serial_lane_two_i, serial_lane_one_i,
    serial_lane_zero_i};

  // address lanes per clock: opcode-style single lane for output reads
  function automatic logic [2:0] addr_width(input kind_e k);
    addr_width = (k == K_DUAL_IO) ? 3'd2 : (k == K_QUAD_IO) ? 3'd4 : 3'd1;
  endfunction

  // data lanes per clock
  function automatic logic [2:0] data_width(input kind_e k);
    data_width = (k == K_DUAL_OUT || k == K_DUAL_IO) ? 3'd2 : 3'd4;
  endfunction

  // shift w lane bits into the low end, top lane being the highest bit
  function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] w,
      input logic [3:0] l);
    case (w)
      3'd2: shift_in = {v[21:0], l[1], l[0]};
      3'd4: shift_in = {v[19:0], l[3], l[2], l[1], l[0]};
      default: shift_in = {v[22:0], l[0]};
    endcase
  endfunction

  // system domain next state
  always_comb begin
    sys_d = sys_q;
    sys_d.qe = quad_lane_enable_bit;
    sys_d.wrap_en = wrap_enable;
    sys_d.wrap_len = wrap_len;
    sys_d.cont_sync = {sys_q.cont_sync[0], keep_q.cont};
    sys_d.data_sync = {sys_q.data_sync[0], fr_q.ph == PH_DATA};
    if (!nrst) begin
      sys_d.qe = 1'b0;
      sys_d.wrap_en = 1'b0;
      sys_d.wrap_len = 2'h0;
      sys_d.cont_sync = SYNC_RST;
      sys_d.data_sync = SYNC_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    sys_q <= sys_d;
  end

  assign cont_read_active = sys_q.cont_sync[1];
  assign data_phase_active = sys_q.data_sync[1];

  // frame sequencer: everything is sampled on the rising edge
  always_comb begin
    logic [2:0] aw;
    logic [2:0] dw;
    logic [23:0] wmask;
    logic [23:0] ainc;
    logic last;
    logic [23:0] mtmp;
    fr_d = fr_q;
    aw = 3'd1;
    dw = 3'd2;
    wmask = 24'h000000;
    ainc = 24'h000000;
    last = 1'b0;
    mtmp = 24'h000000;
    mode_done = 1'b0;
    mode_hit = 1'b0;
    mode_clear = 1'b0;
    fr_d.cnt = fr_q.cnt + 5'h01;
    if (fr_q.ph == PH_START) begin
      // armed continuous mode: first clocks already carry the address
      fr_d.ph = keep_q.cont ? PH_ADDR : PH_OPC;
      fr_d.kind = keep_q.cont_kind;
      fr_d.cnt = 5'h00;
    end
    aw = addr_width(fr_d.kind);
    dw = data_width(fr_d.kind);
    case (fr_d.ph)
      PH_OPC: begin
        fr_d.opc = {fr_q.opc[6:0], lanes[0]};
        if (fr_d.cnt == 5'(OPC_CLKS - 1)) begin
          fr_d.ph = PH_ADDR;
          fr_d.cnt = 5'h1F;
          case (fr_d.opc)
            OPC_DUAL_OUT: fr_d.kind = K_DUAL_OUT;
            OPC_DUAL_IO: fr_d.kind = K_DUAL_IO;
            OPC_QUAD_OUT: begin
              fr_d.kind = K_QUAD_OUT;
              if (!keep_q.cfg_sync[3]) fr_d.ph = PH_IGNORE;
            end
            OPC_QUAD_IO: begin
              fr_d.kind = K_QUAD_IO;
              if (!keep_q.cfg_sync[3]) fr_d.ph = PH_IGNORE;
            end
            OPC_MODE_RESET: begin
              mode_clear = 1'b1;
              fr_d.ph = PH_IGNORE;
            end
            default: fr_d.ph = PH_IGNORE;
          endcase
        end else begin
          fr_d.cnt = fr_q.ph == PH_START ? 5'h00 : fr_d.cnt;
        end
      end
      PH_ADDR: begin
        fr_d.addr = shift_in(fr_q.addr, aw, lanes);
        last = fr_d.cnt == 5'(ADDR_BITS / int'(aw) - 1);
        if (last) begin
          fr_d.cnt = 5'h1F;
          fr_d.ph = (fr_d.kind == K_DUAL_IO || fr_d.kind == K_QUAD_IO) ? PH_MODE : PH_DUMMY;
        end
      end
      PH_MODE: begin
        // mode bits ride the same lanes as the address, low byte kept
        mtmp = shift_in({16'h0000, fr_q.mode}, aw, lanes);
        fr_d.mode = mtmp[7:0];
        if (fr_d.cnt == 5'(8 / int'(aw) - 1)) begin
          mode_done = 1'b1;
          mode_hit = fr_d.mode[7:4] == MODE_KEEP_NIBBLE;
          fr_d.cnt = 5'h1F;
          fr_d.bp = 3'h0;
          fr_d.ph = (fr_d.kind == K_QUAD_IO) ? PH_DUMMY : PH_DATA;
        end
      end
      PH_DUMMY: begin
        last = (fr_d.kind == K_QUAD_IO) ? fr_d.cnt == DUMMY_QIO_CLKS - 5'h01
                                         : fr_d.cnt == DUMMY_OUT_CLKS - 5'h01;
        if (last) begin
          fr_d.ph = PH_DATA;
          fr_d.bp = 3'h0;
        end
      end
      PH_DATA: begin
        // byte done: step the address, folding inside the wrap section
        fr_d.bp = fr_q.bp + dw;
        if (fr_d.bp == 3'h0) begin
          wmask = (WRAP_BASE_MASK << keep_q.cfg_sync[1:0]) | WRAP_BASE_MASK;
          ainc = fr_q.addr + 24'h000001;
          if (fr_q.kind == K_QUAD_IO && keep_q.cfg_sync[2]) begin
            fr_d.addr = (fr_q.addr & ~wmask) | (ainc & wmask);
          end else begin
            fr_d.addr = ainc;
          end
        end
      end
      default: fr_d.ph = PH_IGNORE;
    endcase
    if (keep_q.rst_sync[1] == 1'b0) fr_d.ph = PH_IGNORE;
  end

  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      fr_q <= FRAME_RST;
    end else begin
      fr_q <= fr_d;
    end
  end

  assign mem_addr = fr_q.addr;

  // persistent link state: mode flag moves at the end of a mode byte, on the mode reset opcode and in reset
  always_comb begin
    keep_d = keep_q;
    keep_d.rst_sync = {keep_q.rst_sync[0], nrst};
    keep_d.cfg_meta = {sys_q.qe, sys_q.wrap_en, sys_q.wrap_len};
    keep_d.cfg_sync = keep_q.cfg_meta;
    if (mode_done) begin
      keep_d.cont = mode_hit;
      keep_d.cont_kind = fr_d.kind;
    end
    if (mode_clear) keep_d.cont = 1'b0;
    if (keep_q.rst_sync[1] == 1'b0) begin
      keep_d.cont = 1'b0;
      keep_d.cont_kind = K_DUAL_IO;
    end
  end

  always_ff @(posedge spi_clk) begin
    keep_q <= keep_d;
  end

  // output stage: data bits change on the falling edge and clear on deselect
  always_comb begin
    logic [7:0] sh;
    sh = mem_rdata << fr_q.bp;
    out_d = OUT_RST;
    if (fr_q.ph == PH_DATA) begin
      if (data_width(fr_q.kind) == 3'd4) begin
        out_d.dout = sh[7:4];
        out_d.oe_n = 4'h0;
      end else begin
        out_d.dout = {2'b00, sh[7:6]};
        out_d.oe_n = 4'hC;
      end
    end
  end

  always_ff @(negedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      out_q <= OUT_RST;
    end else begin
      out_q <= out_d;
    end
  end

  assign serial_lane_zero_o = out_q.dout[0];
  assign serial_lane_one_o = out_q.dout[1];
  assign serial_lane_two_o = out_q.dout[2];
  assign serial_lane_three_o = out_q.dout[3];
  assign serial_lane_zero_oe_n = out_q.oe_n[0];
  assign serial_lane_one_oe_n = out_q.oe_n[1];
  assign serial_lane_two_oe_n = out_q.oe_n[2];
  assign serial_lane_three_oe_n = out_q.oe_n[3];
endmodule

// ---- shared/fast_read_pkg.sv ----
// Purpose: shared constants and types for the multi-lane fast read engine
// Assumes: 24-bit byte addresses, opcodes arrive on lane zero
// Notes: opcode and dummy counts are in serial clocks of the link; ADDR_BITS is in bits
package fast_read_pkg;
  localparam logic [7:0] OPC_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OPC_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OPC_DUAL_IO = 8'hBB;
  localparam logic [7:0] OPC_QUAD_IO = 8'hEB;
  localparam logic [7:0] OPC_MODE_RESET = 8'hFF;
  localparam logic [3:0] MODE_KEEP_NIBBLE = 4'hA;
  localparam int ADDR_BITS = 24;
  localparam int OPC_CLKS = 8;
  localparam logic [4:0] DUMMY_OUT_CLKS = 5'h08;
  localparam logic [4:0] DUMMY_QIO_CLKS = 5'h04;
  localparam logic [23:0] WRAP_BASE_MASK = 24'h000007;
  localparam logic [3:0] OE_N_IDLE = 4'hF;
  localparam logic [1:0] SYNC_RST = 2'h0;

  typedef enum logic [2:0] {
    PH_START = 3'b000,
    PH_OPC = 3'b001,
    PH_ADDR = 3'b010,
    PH_MODE = 3'b011,
    PH_DUMMY = 3'b100,
    PH_DATA = 3'b101,
    PH_IGNORE = 3'b110
  } phase_e;

  typedef enum logic [1:0] {
    K_DUAL_OUT = 2'b00,
    K_QUAD_OUT = 2'b01,
    K_DUAL_IO = 2'b10,
    K_QUAD_IO = 2'b11
  } kind_e;
endpackage
